// ===== pkg/bmf_pkg.sv
// Functional notes
// RULE1 - Width selects fix write and read widths.
// RULE2 - Decode width selects per five-row table.
// RULE3 - Byte order select low big, high little.
// RULE4 - Unused upper write lines are ignored.
// RULE5 - Standard mode: flag shows memory empty.
// RULE6 - Fall-through: flag shows output word valid.
// RULE7 - Standard mode: flag shows memory full.
// RULE8 - Fall-through: flag shows a free location.
// RULE9 - Offset selects plus load pick default offset.
// RULE10 - Serial input picks timing, then serial data.
// RULE11 - Half-full flag compares count to half.
// RULE12 - Parity select low non-interspersed, high interspersed.
// RULE13 - Parity only affects parallel offset loads.
// RULE14 - Interspersed parity bits 8,17,26,35 dropped.
// RULE15 - Load input picks serial or parallel programming.
// RULE16 - Load high steers strobes to offset registers.
// RULE17 - Configuration inputs stay steady after reset.
// RULE18 - Configuration latched at reset end, kept.
package bmf_pkg;
	localparam int DEPTH_LOG = 4;
	localparam int DEPTH = 16;
	localparam int HALF = 8;
	localparam int DW = 36;
	localparam int OFW = 4;
	localparam logic [DEPTH_LOG:0] HALF_CNT = 5'h08;
	localparam logic [DEPTH_LOG:0] FULL_CNT = 5'h10;
	localparam logic [OFW-1:0] DEF_OFS0 = 4'h1;
	localparam logic [OFW-1:0] DEF_OFS1 = 4'h2;
	localparam logic [OFW-1:0] DEF_OFS2 = 4'h3;
	localparam logic [OFW-1:0] DEF_OFS3 = 4'h4;
	localparam logic [OFW-1:0] DEF_OFS4 = 4'h5;
	localparam logic [OFW-1:0] DEF_OFS5 = 4'h6;
	localparam logic [OFW-1:0] DEF_OFS6 = 4'h7;
	localparam logic [OFW-1:0] DEF_OFS7 = 4'h8;
	typedef enum logic [1:0] {BMF_W36, BMF_W18, BMF_W9} bmf_width_t;
	typedef enum {BMF_RESET, BMF_RUN} bmf_state_t;
endpackage

// ===== rtl/bmf_cfg_decode.sv
`timescale 1ns/1ps
// Width decode of the bus-matching table.
module bmf_cfg_decode (
	input wire logic widthConfigSelect,
	input wire logic writeWidthSelect,
	input wire logic readWidthSelect,
	output bmf_pkg::bmf_width_t writeWidth,
	output bmf_pkg::bmf_width_t readWidth
);
	// Non-matching mode is always 36 in and 36 out.
	assign writeWidth = !widthConfigSelect || !writeWidthSelect ? bmf_pkg::BMF_W36 : // RULE2
		(readWidthSelect ? bmf_pkg::BMF_W9 : bmf_pkg::BMF_W18);
	assign readWidth = !widthConfigSelect || writeWidthSelect ? bmf_pkg::BMF_W36 : // RULE2
		(readWidthSelect ? bmf_pkg::BMF_W9 : bmf_pkg::BMF_W18);
endmodule

// ===== rtl/bmf_fifo_flags.sv
`timescale 1ns/1ps
// Configuration capture and status flags of a small bus-matching FIFO.
module bmf_fifo_flags (
	input wire logic clk,
	input wire logic nrst,
	input wire logic fullResetN,
	input wire logic widthConfigSelect,
	input wire logic writeWidthSelect,
	input wire logic readWidthSelect,
	input wire logic byteOrderSelect,
	input wire logic defaultOffsetSelLo,
	input wire logic defaultOffsetSelHi,
	input wire logic fallthroughSerialIn,
	input wire logic parityPlacementSelect,
	input wire logic offsetLoadEnable,
	input wire logic serialEnable,
	input wire logic writeEnable,
	input wire logic readEnable,
	input wire logic [35:0] dataIn,
	output logic [35:0] dataOut,
	output logic emptyFlag,
	output logic fullIndicator,
	output logic halfFullFlag,
	output logic almostEmptyFlag,
	output logic almostFullFlag,
	output logic [1:0] writeWidthCfg,
	output logic [1:0] readWidthCfg,
	output logic littleEndianCfg,
	output logic fallThroughTiming,
	output logic interspersedCfg,
	output logic serialProgCfg,
	output logic irq
);
	bmf_pkg::bmf_width_t wWidthRaw;
	bmf_pkg::bmf_width_t rWidthRaw;
	bmf_pkg::bmf_state_t state_q;
	logic [35:0] mem [bmf_pkg::DEPTH];
	logic [bmf_pkg::DEPTH_LOG-1:0] wPtr_q;
	logic [bmf_pkg::DEPTH_LOG-1:0] rPtr_q;
	logic [bmf_pkg::DEPTH_LOG:0] count_q;
	logic [bmf_pkg::OFW-1:0] emptyOfs_q;
	logic [bmf_pkg::OFW-1:0] fullOfs_q;
	logic [1:0] wWidth_q;
	logic [1:0] rWidth_q;
	logic littleEnd_q;
	logic fall_through_timing_q;
	logic ipar_q;
	logic serial_q;
	logic outValid_q;
	logic [35:0] dataOut_q;
	logic serSel_q;
	logic rdSel_q;
	logic [bmf_pkg::OFW-1:0] serShift_q;
	logic [1:0] serCnt_q;

	// Width decode is shared with other users of the same table.
	bmf_cfg_decode bmf_cfg_decode_i (
		.widthConfigSelect(widthConfigSelect),
		.writeWidthSelect(writeWidthSelect),
		.readWidthSelect(readWidthSelect),
		.writeWidth(wWidthRaw),
		.readWidth(rWidthRaw)
	);

	// Keep only the lanes that the write width uses.
	function automatic logic [35:0] maskIn(input logic [1:0] w, input logic [35:0] d);
		logic [35:0] m;
		m = d;
		if (w == 2'(bmf_pkg::BMF_W18))
			m = {18'h00000, d[17:0]};
		else if (w == 2'(bmf_pkg::BMF_W9))
			m = {27'h0000000, d[8:0]};
		return m;
	endfunction

	// Pick one of eight default offsets.
	function automatic logic [bmf_pkg::OFW-1:0] defOfs(input logic [2:0] s);
		logic [bmf_pkg::OFW-1:0] o;
		o = bmf_pkg::DEF_OFS0;
		unique case (s)
			3'h0: o = bmf_pkg::DEF_OFS0;
			3'h1: o = bmf_pkg::DEF_OFS1;
			3'h2: o = bmf_pkg::DEF_OFS2;
			3'h3: o = bmf_pkg::DEF_OFS3;
			3'h4: o = bmf_pkg::DEF_OFS4;
			3'h5: o = bmf_pkg::DEF_OFS5;
			3'h6: o = bmf_pkg::DEF_OFS6;
			3'h7: o = bmf_pkg::DEF_OFS7;
		endcase
		return o;
	endfunction

	// Decoded strobes; load high sends strobes to the offset registers.
	wire running = (state_q == bmf_pkg::BMF_RUN);
	wire ofsWrPar = running && offsetLoadEnable && writeEnable && !serial_q; // RULE16
	wire ofsWrSer = running && offsetLoadEnable && serialEnable && serial_q; // RULE16 RULE10
	wire ofsRd = running && offsetLoadEnable && readEnable; // RULE16
	wire memFull = (count_q == bmf_pkg::FULL_CNT);
	wire memEmpty = (count_q == '0);
	wire doWrite = running && !offsetLoadEnable && writeEnable && !memFull;
	wire fwftLoad = fall_through_timing_q && !memEmpty && (!outValid_q || readEnable);
	wire doRead = running && !offsetLoadEnable && !memEmpty && (fall_through_timing_q ? fwftLoad : readEnable);
	wire [35:0] wrWord = maskIn(wWidth_q, dataIn); // RULE4
	// Parity lanes are stripped only from offset loads, never from data.
	wire [35:0] parWord = ipar_q ? {1'b0, dataIn[34:27], dataIn[25:18], dataIn[16:9], dataIn[7:0], 3'h0} : // RULE14 RULE13
		{4'h0, dataIn[31:0]};
	wire [bmf_pkg::OFW-1:0] parOfs = ipar_q ? parWord[bmf_pkg::OFW+2:3] : parWord[bmf_pkg::OFW-1:0]; // RULE14
	wire [bmf_pkg::DEPTH_LOG:0] countNext = count_q + 5'(doWrite) - 5'(doRead);
	wire [bmf_pkg::DEPTH_LOG:0] freeNext = bmf_pkg::FULL_CNT - countNext;
	wire outValidNext = fall_through_timing_q ? (doRead || (outValid_q && !readEnable)) : 1'b0;

	// Configuration capture: held in reset state while full reset is low, latched at its release.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_q <= bmf_pkg::BMF_RESET;
		else
			state_q <= fullResetN ? bmf_pkg::BMF_RUN : bmf_pkg::BMF_RESET;
	end

	// Latch all straps but the default offset selects while full reset is active; frozen afterward.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wWidth_q <= 2'(bmf_pkg::BMF_W36);
			rWidth_q <= 2'(bmf_pkg::BMF_W36);
			littleEnd_q <= 1'b0;
			fall_through_timing_q <= 1'b0;
			ipar_q <= 1'b0;
			serial_q <= 1'b0;
		end
		else if (!fullResetN)
		begin
			wWidth_q <= 2'(wWidthRaw); // RULE1 RULE18
			rWidth_q <= 2'(rWidthRaw); // RULE1 RULE18
			littleEnd_q <= byteOrderSelect; // RULE3
			fall_through_timing_q <= fallthroughSerialIn; // RULE10
			ipar_q <= parityPlacementSelect; // RULE12
			serial_q <= !offsetLoadEnable; // RULE15
		end
	end

	// Offset registers: defaults at reset, then serial or parallel loads in turn.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			emptyOfs_q <= bmf_pkg::DEF_OFS0;
			fullOfs_q <= bmf_pkg::DEF_OFS0;
			serSel_q <= 1'b0;
			rdSel_q <= 1'b0;
			serShift_q <= '0;
			serCnt_q <= '0;
		end
		else if (!fullResetN)
		begin
			emptyOfs_q <= defOfs({offsetLoadEnable, defaultOffsetSelHi, defaultOffsetSelLo}); // RULE9
			fullOfs_q <= defOfs({offsetLoadEnable, defaultOffsetSelHi, defaultOffsetSelLo}); // RULE9
			serSel_q <= 1'b0;
			rdSel_q <= 1'b0;
			serShift_q <= '0;
			serCnt_q <= '0;
		end
		else
		begin
			if (ofsWrPar)
			begin
				if (serSel_q)
					fullOfs_q <= parOfs;
				else
					emptyOfs_q <= parOfs;
				serSel_q <= !serSel_q;
			end
			else if (ofsWrSer)
			begin
				serShift_q <= {serShift_q[bmf_pkg::OFW-2:0], fallthroughSerialIn}; // RULE10
				serCnt_q <= serCnt_q + 2'h1;
				if (serCnt_q == 2'h3)
				begin
					if (serSel_q)
						fullOfs_q <= {serShift_q[bmf_pkg::OFW-2:0], fallthroughSerialIn};
					else
						emptyOfs_q <= {serShift_q[bmf_pkg::OFW-2:0], fallthroughSerialIn};
					serSel_q <= !serSel_q;
				end
			end
			if (ofsRd)
				rdSel_q <= !rdSel_q;
		end
	end

	// Memory array write; stored words are never touched by the parity setting.
	always_ff @(posedge clk)
	begin
		if (doWrite)
			mem[wPtr_q] <= wrWord; // RULE13
	end

	// Pointers, count and output register.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wPtr_q <= '0;
			rPtr_q <= '0;
			count_q <= '0;
			outValid_q <= 1'b0;
			dataOut_q <= '0;
		end
		else if (!fullResetN)
		begin
			wPtr_q <= '0;
			rPtr_q <= '0;
			count_q <= '0;
			outValid_q <= 1'b0;
			dataOut_q <= '0;
		end
		else
		begin
			if (doWrite)
				wPtr_q <= wPtr_q + 4'h1;
			if (doRead)
				rPtr_q <= rPtr_q + 4'h1;
			count_q <= countNext;
			outValid_q <= outValidNext;
			if (doRead)
				dataOut_q <= mem[rPtr_q];
			else if (ofsRd)
				dataOut_q <= {32'h00000000, rdSel_q ? fullOfs_q : emptyOfs_q};
		end
	end

	// Registered flags, active low except irq, computed from the next-state count and next output-valid state.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			emptyFlag <= 1'b0;
			fullIndicator <= 1'b1;
			halfFullFlag <= 1'b1;
			almostEmptyFlag <= 1'b0;
			almostFullFlag <= 1'b1;
			irq <= 1'b0;
		end
		else if (!fullResetN)
		begin
			emptyFlag <= fallthroughSerialIn;
			fullIndicator <= !fallthroughSerialIn;
			halfFullFlag <= 1'b1;
			almostEmptyFlag <= 1'b0;
			almostFullFlag <= 1'b1;
			irq <= 1'b0;
		end
		else
		begin
			emptyFlag <= fall_through_timing_q ? !outValidNext : (countNext != '0); // RULE5 RULE6
			fullIndicator <= fall_through_timing_q ? (countNext == bmf_pkg::FULL_CNT) : // RULE8
				(countNext != bmf_pkg::FULL_CNT); // RULE7
			halfFullFlag <= !(countNext > bmf_pkg::HALF_CNT); // RULE11
			almostEmptyFlag <= (countNext >= 5'(emptyOfs_q));
			almostFullFlag <= (freeNext > 5'(fullOfs_q));
			irq <= (countNext > bmf_pkg::HALF_CNT);
		end
	end

	// Straight copies of the output register and the captured configuration to the outputs.
	assign dataOut = dataOut_q;
	assign writeWidthCfg = wWidth_q;
	assign readWidthCfg = rWidth_q;
	assign littleEndianCfg = littleEnd_q;
	assign fallThroughTiming = fall_through_timing_q;
	assign interspersedCfg = ipar_q;
	assign serialProgCfg = serial_q;

	a_cfg_stable: assert property (@(posedge clk) disable iff (!nrst)
		(fullResetN && $past(fullResetN)) |-> $stable(fall_through_timing_q) && $stable(wWidth_q)) // RULE18
		else $error("Configuration changed after reset.");
	a_std_empty: assert property (@(posedge clk) disable iff (!nrst)
		(running && fullResetN && !fall_through_timing_q) |=> (emptyFlag == (count_q != '0))) // RULE5
		else $error("Empty flag wrong in standard mode.");
	a_std_full: assert property (@(posedge clk) disable iff (!nrst)
		(running && fullResetN && !fall_through_timing_q) |=> (fullIndicator == (count_q != bmf_pkg::FULL_CNT))) // RULE7
		else $error("Full flag wrong in standard mode.");
	a_ft_valid: assert property (@(posedge clk) disable iff (!nrst)
		(running && fullResetN && fall_through_timing_q) |=> (emptyFlag == !outValid_q)) // RULE6
		else $error("Output valid flag wrong.");
	a_ft_space: assert property (@(posedge clk) disable iff (!nrst)
		(running && fullResetN && fall_through_timing_q) |=> (fullIndicator == (count_q == bmf_pkg::FULL_CNT))) // RULE8
		else $error("Input space flag wrong.");
	a_half_full: assert property (@(posedge clk) disable iff (!nrst)
		running |=> (halfFullFlag == !(count_q > bmf_pkg::HALF_CNT))) // RULE11
		else $error("Half-full flag wrong.");
	a_load_steer: assert property (@(posedge clk) disable iff (!nrst)
		(running && fullResetN && offsetLoadEnable) |=> $stable(wPtr_q) && $stable(rPtr_q)) // RULE16
		else $error("Data pointer moved during offset access.");
	a_narrow_ignore: assert property (@(posedge clk) disable iff (!nrst)
		(doWrite && wWidth_q == 2'(bmf_pkg::BMF_W9)) |-> (wrWord[35:9] == '0)) // RULE4
		else $error("Unused write lanes leaked.");
	a_width_decode: assert property (@(posedge clk) disable iff (!nrst)
		(!fullResetN && !widthConfigSelect) |=> (wWidth_q == 2'(bmf_pkg::BMF_W36))) // RULE2
		else $error("Width decode wrong.");
	c_fill: cover property (@(posedge clk) disable iff (!nrst) running && memFull);
	c_ft_read: cover property (@(posedge clk) disable iff (!nrst) fall_through_timing_q && doRead);
	c_par_load: cover property (@(posedge clk) disable iff (!nrst) ofsWrPar && ipar_q);
	c_ser_load: cover property (@(posedge clk) disable iff (!nrst) ofsWrSer);
endmodule

// ===== sim/bmf_stream_partner.sv
`timescale 1ns/1ps
// Far side: holds the straps after full reset and passes the bench's strobes.
module bmf_stream_partner (
	input wire logic clk,
	input wire logic fullResetN,
	input wire logic [8:0] cfgIn,
	input wire logic wrCmd,
	input wire logic rdCmd,
	input wire logic ldCmd,
	input wire logic serCmd,
	input wire logic [35:0] wordIn,
	output logic widthConfigSelect,
	output logic writeWidthSelect,
	output logic readWidthSelect,
	output logic byteOrderSelect,
	output logic defaultOffsetSelLo,
	output logic defaultOffsetSelHi,
	output logic fallthroughSerialIn,
	output logic parityPlacementSelect,
	output logic offsetLoadEnable,
	output logic serialEnable,
	output logic writeEnable,
	output logic readEnable,
	output logic [35:0] dataIn
);
	logic [8:0] strapQ = 9'h000;
	logic serialQ = 1'b0;
	// Straps follow the request during full reset and stay frozen after it; the serial line toggles.
	always_ff @(posedge clk)
	begin
		if (!fullResetN)
			strapQ <= cfgIn;
		serialQ <= ~serialQ;
	end
	// Strap pins carry the request in reset and the frozen copy afterwards.
	assign widthConfigSelect = fullResetN ? strapQ[0] : cfgIn[0];
	assign writeWidthSelect = fullResetN ? strapQ[1] : cfgIn[1];
	assign readWidthSelect = fullResetN ? strapQ[2] : cfgIn[2];
	assign byteOrderSelect = fullResetN ? strapQ[3] : cfgIn[3];
	assign defaultOffsetSelLo = fullResetN ? strapQ[4] : cfgIn[4];
	assign defaultOffsetSelHi = fullResetN ? strapQ[5] : cfgIn[5];
	assign parityPlacementSelect = fullResetN ? strapQ[7] : cfgIn[7];
	// The shared pin becomes a busy serial line after reset, which must not disturb the timing mode.
	// While a serial load is strobed it carries the lowest bit of the offered word.
	assign fallthroughSerialIn = fullResetN ? (serCmd ? wordIn[0] : serialQ) : cfgIn[6];
	assign offsetLoadEnable = fullResetN ? ldCmd : cfgIn[8];
	assign serialEnable = serCmd;
	assign writeEnable = wrCmd;
	assign readEnable = rdCmd;
	// The data bus shows the inverted offered word whenever no write is offered.
	assign dataIn = wrCmd ? wordIn : ~wordIn;
endmodule

// ===== sim/test_bmf_fifo_flags.sv
`timescale 1ns/1ps
// Self-checking bench: strap sweeps, fill and drain against a counting model.
module test_bmf_fifo_flags;
	logic clk, nrst, fullResetN, wrCmd, rdCmd, ldCmd, serCmd;
	logic [8:0] cfg, cfgV;
	logic [7:0] sv;
	logic [35:0] word, dataIn, dataOut;
	logic wcs, wws, rws, bos, osl, osh, fsi, pps, ole, sen, wen, ren;
	logic emptyFlag, fullIndicator, halfFullFlag, almostEmptyFlag, almostFullFlag;
	logic littleEndianCfg, fallThroughTiming, interspersedCfg, serialProgCfg, irq;
	logic [1:0] writeWidthCfg, readWidthCfg;
	int nFail = 0, checksDone = 0, cnt, ov, ofsE, ofsF, row, dummy;
	logic [35:0] q[$];
	logic [35:0] mask;
	logic [2:0] rowSel[5] = '{3'b000, 3'b001, 3'b101, 3'b011, 3'b111};
	logic [1:0] expW[5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
	logic [1:0] expR[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
	logic [3:0] defOfs[8] = '{bmf_pkg::DEF_OFS0, bmf_pkg::DEF_OFS1, bmf_pkg::DEF_OFS2, bmf_pkg::DEF_OFS3,
		bmf_pkg::DEF_OFS4, bmf_pkg::DEF_OFS5, bmf_pkg::DEF_OFS6, bmf_pkg::DEF_OFS7};

	bmf_stream_partner bmf_stream_partner_i (.clk(clk), .fullResetN(fullResetN), .cfgIn(cfg), .wrCmd(wrCmd),
		.rdCmd(rdCmd), .ldCmd(ldCmd), .serCmd(serCmd), .wordIn(word), .widthConfigSelect(wcs),
		.writeWidthSelect(wws), .readWidthSelect(rws),
		.byteOrderSelect(bos), .defaultOffsetSelLo(osl), .defaultOffsetSelHi(osh), .fallthroughSerialIn(fsi),
		.parityPlacementSelect(pps), .offsetLoadEnable(ole), .serialEnable(sen), .writeEnable(wen),
		.readEnable(ren), .dataIn(dataIn));
	bmf_fifo_flags bmf_fifo_flags_i (.clk(clk), .nrst(nrst), .fullResetN(fullResetN), .widthConfigSelect(wcs),
		.writeWidthSelect(wws), .readWidthSelect(rws), .byteOrderSelect(bos), .defaultOffsetSelLo(osl),
		.defaultOffsetSelHi(osh), .fallthroughSerialIn(fsi), .parityPlacementSelect(pps),
		.offsetLoadEnable(ole), .serialEnable(sen), .writeEnable(wen), .readEnable(ren), .dataIn(dataIn),
		.dataOut(dataOut), .emptyFlag(emptyFlag), .fullIndicator(fullIndicator), .halfFullFlag(halfFullFlag),
		.almostEmptyFlag(almostEmptyFlag), .almostFullFlag(almostFullFlag), .writeWidthCfg(writeWidthCfg),
		.readWidthCfg(readWidthCfg), .littleEndianCfg(littleEndianCfg), .fallThroughTiming(fallThroughTiming),
		.interspersedCfg(interspersedCfg), .serialProgCfg(serialProgCfg), .irq(irq));

	// Clock of 5 ns period.
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Compares one value and counts the outcome.
	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		checksDone++;
		if (g !== e)
		begin
			nFail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One strobe cycle with its data word, then time for the registered answer to settle.
	task automatic op(input logic w, input logic r, input logic l, input logic s, input logic [35:0] d);
		@(posedge clk);
		wrCmd <= w;
		rdCmd <= r;
		ldCmd <= l;
		serCmd <= s;
		word <= d;
		@(posedge clk);
		wrCmd <= 1'b0;
		rdCmd <= 1'b0;
		ldCmd <= 1'b0;
		serCmd <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// Captured configuration against the straps requested in reset.
	task automatic chkCfg();
		chk("writeWidthCfg", expW[row], writeWidthCfg);
		chk("readWidthCfg", expR[row], readWidthCfg);
		chk("littleEndianCfg", cfg[3], littleEndianCfg);
		chk("fallThroughTiming", cfg[6], fallThroughTiming);
		chk("interspersedCfg", cfg[7], interspersedCfg);
		chk("serialProgCfg", !cfg[8], serialProgCfg);
	endtask

	// Status flags against the model's word count.
	task automatic chkFlags();
		chk("emptyFlag", cfg[6] ? !ov : (cnt != 0), emptyFlag);
		chk("fullIndicator", cfg[6] ? (cnt == bmf_pkg::DEPTH) : (cnt != bmf_pkg::DEPTH), fullIndicator);
		chk("halfFullFlag", !(cnt > bmf_pkg::HALF), halfFullFlag);
		chk("irq", cnt > bmf_pkg::HALF, irq);
		chk("almostEmptyFlag", cnt >= ofsE, almostEmptyFlag);
		chk("almostFullFlag", (bmf_pkg::DEPTH - cnt) > ofsF, almostFullFlag);
	endtask

	// Fall-through model: the output register holds one word beside the memory count.
	task automatic upd();
		if (cfg[6] && !ov && cnt > 0)
		begin
			ov = 1;
			cnt--;
		end
		if (ov)
			chk("dataOut", q[0], dataOut);
		chkFlags();
	endtask

	// Watchdog well beyond the expected run length.
	initial
	begin
		repeat (20000) @(posedge clk);
		nFail++;
		giveVerdict();
	end

	// Main sequence: each strap set, offset programming, then a fill and a drain past both ends.
	initial
	begin
		nrst = 1'b0;
		fullResetN = 1'b0;
		wrCmd = 1'b0;
		rdCmd = 1'b0;
		ldCmd = 1'b0;
		serCmd = 1'b0;
		cfg = 9'h000;
		word = 36'h0;
		dummy = $urandom(32'h779e85ad);
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int it = 0; it < 10; it++)
		begin
			row = it % 5;
			cfgV = 9'($urandom % 512);
			cfgV[2:0] = rowSel[row];
			cfgV[6] = it[0];
			@(posedge clk);
			cfg <= cfgV;
			fullResetN <= 1'b0;
			repeat (2) @(posedge clk);
			fullResetN <= 1'b1;
			repeat (3) @(posedge clk);
			#1;
			cnt = 0;
			ov = 0;
			ofsE = defOfs[{cfg[8], cfg[5], cfg[4]}];
			ofsF = ofsE;
			mask = (expW[row] == 2'h2) ? 36'h1ff : (expW[row] == 2'h1) ? 36'h3ffff : 36'hfffffffff;
			chkCfg();
			chkFlags();
			// Load both offsets by the method chosen in reset, empty first, then read them back.
			ofsE = $urandom % 16;
			ofsF = $urandom % 16;
			sv = {4'(ofsE), 4'(ofsF)};
			if (cfg[8])
			begin
				op(1'b1, 1'b0, 1'b1, 1'b0, {32'($urandom), sv[7:4]});
				op(1'b1, 1'b0, 1'b1, 1'b0, {32'($urandom), sv[3:0]});
			end
			else
			begin
				for (int k = 7; k >= 0; k--)
					op(1'b0, 1'b0, 1'b1, 1'b1, {35'($urandom), sv[k]});
			end
			op(1'b0, 1'b1, 1'b1, 1'b0, word);
			chk("emptyOfs", 36'(sv[7:4]), dataOut);
			op(1'b0, 1'b1, 1'b1, 1'b0, word);
			chk("fullOfs", 36'(sv[3:0]), dataOut);
			chkFlags();
			for (int k = 0; k <= bmf_pkg::DEPTH + 1; k++)
			begin
				op(1'b1, 1'b0, 1'b0, 1'b0, 36'({$urandom, $urandom}));
				if (cnt < bmf_pkg::DEPTH)
				begin
					q.push_back(word & mask);
					cnt++;
				end
				upd();
			end
			for (int k = 0; k <= bmf_pkg::DEPTH + 1; k++)
			begin
				op(1'b0, 1'b1, 1'b0, 1'b0, word);
				if (cfg[6] && ov)
				begin
					void'(q.pop_front());
					ov = 0;
				end
				else if (!cfg[6] && cnt > 0)
				begin
					cnt--;
					chk("dataOut", q.pop_front(), dataOut);
				end
				upd();
			end
			chkCfg();
		end
		giveVerdict();
	end
endmodule
